// *** hw/rx_framer_boc_sig_ctrl.sv ***
// Behaviour
// - D4 alarm: bit 2 zero all channels
// - Select set: frame 12 S-bit one alarms
// - Sa enables Sa4..Sa8 bits 4..0 reset zero
// - Enabled Sa change sets latched status bit
// - Port copy decoded at 200h times index
// - BOC reset bit self clears quickly
// - Filter settings apply after BOC reset
// - Disintegration field picks 16/32/48/64 bits
// - Filter field picks 1/3/5/7 patterns
// - Never integrate and disintegrate together
// - Thirty-two idle code bytes at 020h
// - Idle codes 1-24 T1, 25-32 E1
// - Force-ones replaces robbed bits on serial out
// - Signaling output keeps real received bits
// - Milliwatt enable replaces channel data
// - Sixteen read-only bytes at 040h, first 12 signaling
// - Signaling control bit 4 enables forcing
// - Freeze on sync loss; D4 repeats AB
`timescale 1ns/1ps
`default_nettype none
module rx_framer_boc_sig_ctrl #(
  parameter logic [1:0] PORT_INDEX = 2'h0,
  parameter logic [63:0] MW_CODE = 64'h1E0B0B1E9E8B8B9E
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire rx_framer_pkg::rx_stream_s rx_in,
  output rx_framer_pkg::rx_out_s rx_out,
  output logic remote_alarm,
  output logic bit_code_valid_status,
  output logic receive_latched_status_7
);
  import rx_framer_pkg::*;

  logic [7:0] sig_ctrl_q;
  logic [7:0] sa_en_q;
  logic [7:0] boc_ctrl_q;
  logic [7:0] idle_mem_q [ALL_CHANNELS];
  logic [3:0] sig_mem_q [T1_CHANNELS];
  logic [23:0] force1_q;
  logic [23:0] mw_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [10:0] addr_q;
  logic wr_fire;
  logic [8:0] wr_off;
  logic [7:0] wdat;
  logic [3:0] boc_cnt_q;
  logic [1:0] filt_act_q;
  logic [1:0] disint_act_q;
  logic [2:0] integ_cnt_q;
  logic [6:0] disint_cnt_q;
  logic bc_valid_q;
  logic [4:0] sa_prev_q;
  logic sa_prev_ok_q;
  logic sa_flag_q;
  logic sa_event;
  logic sa_clear;
  logic alarm_acc_q;
  logic alarm_q;
  logic [2:0] mw_phase_q;
  logic st_acc_now;

  function automatic logic [2:0] filter_count(input logic [1:0] code);
    case (code)
      2'h0: filter_count = 3'h0;
      2'h1: filter_count = 3'h3;
      2'h2: filter_count = 3'h5;
      default: filter_count = 3'h7;
    endcase
  endfunction

  function automatic logic [6:0] disint_count(input logic [1:0] code);
    disint_count = 7'(({5'h0, code} + 7'h1) * DISINT_UNIT);
  endfunction

  function automatic logic port_hit(input logic [10:0] idx);
    port_hit = (idx[10:PORT_IDX_LSB] == PORT_INDEX);
  endfunction

  // Bus slave: writes take effect at the end of the data phase, reads
  // insert one wait state so a read right after a write sees new data.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 11'h0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
    end else if (clk_en) begin
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= {24'h0, read_byte(addr_q)};
      end else if (hready) begin
        wr_pend_q <= hsel && htrans == HTRANS_NONSEQ && hwrite;
        rd_pend_q <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
        hreadyout <= !(hsel && htrans == HTRANS_NONSEQ && !hwrite);
        addr_q <= haddr[12:2];
      end
    end
  end

  assign hresp = 1'b0;
  // Port decode
  // Port stride decode
  assign wr_fire = clk_en && wr_pend_q && port_hit(addr_q);
  assign wr_off = addr_q[8:0];
  assign wdat = hwdata[7:0];

  function automatic logic [7:0] read_byte(input logic [10:0] idx);
    logic [8:0] off;
    logic [4:0] k;
    off = idx[8:0];
    k = 5'(off - OFF_RECEIVE_SIGNALING_OUT_FIRST);
    read_byte = 8'h0;
    if (port_hit(idx)) begin
      if (off == OFF_SIG_CTRL) read_byte = sig_ctrl_q;
      else if (off == OFF_SA_IRQ_EN) read_byte = sa_en_q;
      else if (off == OFF_BOC_CTRL) read_byte = boc_ctrl_q;
      else if (off >= OFF_IDLE_FIRST && off <= OFF_IDLE_LAST) read_byte = idle_mem_q[5'(off - OFF_IDLE_FIRST)];
      else if (off >= OFF_RECEIVE_SIGNALING_OUT_FIRST && off <= OFF_RECEIVE_SIGNALING_OUT_LAST) begin
        if (k < 5'(RECEIVE_SIGNALING_OUT_T1_BYTES)) read_byte = {sig_mem_q[k], sig_mem_q[5'(k + 5'(RECEIVE_SIGNALING_OUT_T1_BYTES))]};
      end
      else if (off >= OFF_FORCE1_FIRST && off < OFF_MW_FIRST) read_byte = force1_q[8 * (off - OFF_FORCE1_FIRST) +: 8];
      else if (off >= OFF_MW_FIRST && off < OFF_STATUS) read_byte = mw_q[8 * (off - OFF_MW_FIRST) +: 8];
      else if (off == OFF_STATUS) read_byte = {5'h0, alarm_q, bc_valid_q, sa_flag_q};
    end
  endfunction

  // Plain control registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sig_ctrl_q <= RST_BYTE;
      sa_en_q <= RST_BYTE;
      force1_q <= 24'h0;
      mw_q <= 24'h0;
    end else if (wr_fire) begin
      if (wr_off == OFF_SIG_CTRL) sig_ctrl_q <= wdat & SIG_CTRL_MASK;
      if (wr_off == OFF_SA_IRQ_EN) sa_en_q <= wdat & SA_IRQ_MASK;
      if (wr_off >= OFF_FORCE1_FIRST && wr_off < OFF_MW_FIRST) force1_q[8 * (wr_off - OFF_FORCE1_FIRST) +: 8] <= wdat;
      if (wr_off >= OFF_MW_FIRST && wr_off < OFF_STATUS) mw_q[8 * (wr_off - OFF_MW_FIRST) +: 8] <= wdat;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < ALL_CHANNELS; i++) idle_mem_q[i] <= RST_BYTE;
    end else if (wr_fire && wr_off >= OFF_IDLE_FIRST && wr_off <= OFF_IDLE_LAST) begin
      idle_mem_q[5'(wr_off - OFF_IDLE_FIRST)] <= wdat;
    end
  end

  // BOC control; a host write of the reset bit wins over self clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      boc_ctrl_q <= RST_BYTE;
      boc_cnt_q <= 4'h0;
    end else if (clk_en) begin
      if (wr_fire && wr_off == OFF_BOC_CTRL) begin
        boc_ctrl_q <= (wdat & BOC_CTRL_MASK) | (wdat & 8'h80) | (boc_ctrl_q & 8'h80);
        boc_cnt_q <= 4'h0;
      end else if (boc_ctrl_q[BIT_BOC_RESET]) begin
        if (boc_cnt_q == BOC_RST_LEN - 4'h1) begin
          boc_ctrl_q[BIT_BOC_RESET] <= 1'b0;
          boc_cnt_q <= 4'h0;
        end else boc_cnt_q <= boc_cnt_q + 4'h1;
      end
    end
  end

  // BOC detector
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      filt_act_q <= 2'h0;
      disint_act_q <= 2'h0;
      integ_cnt_q <= 3'h0;
      disint_cnt_q <= 7'h0;
      bc_valid_q <= 1'b0;
    end else if (clk_en) begin
      if (boc_ctrl_q[BIT_BOC_RESET]) begin
        integ_cnt_q <= 3'h0;
        disint_cnt_q <= 7'h0;
        bc_valid_q <= 1'b0;
        if (boc_cnt_q == BOC_RST_LEN - 4'h1) begin
          filt_act_q <= boc_ctrl_q[2:1];
          disint_act_q <= boc_ctrl_q[5:4];
        end
      end else if (!bc_valid_q) begin
        if (rx_in.boc_pattern_err) integ_cnt_q <= 3'h0;
        else if (rx_in.boc_pattern_ok) begin
          if (integ_cnt_q + 3'h1 >= filter_count(filt_act_q)) begin
            bc_valid_q <= 1'b1;
            integ_cnt_q <= 3'h0;
            disint_cnt_q <= 7'h0;
          end else integ_cnt_q <= integ_cnt_q + 3'h1;
        end
      end else begin
        if (rx_in.boc_pattern_ok) disint_cnt_q <= 7'h0;
        else if (rx_in.boc_bit) begin
          if (disint_cnt_q + 7'h1 == disint_count(disint_act_q)) begin
            bc_valid_q <= 1'b0;
            disint_cnt_q <= 7'h0;
          end else disint_cnt_q <= disint_cnt_q + 7'h1;
        end
      end
    end
  end

  // Sa change detect, set wins over a host clear
  // Compare with previous
  assign sa_event = !rx_in.t1_mode && rx_in.sa_valid && sa_prev_ok_q && (((rx_in.sa_bits ^ sa_prev_q) & sa_en_q[4:0]) != 5'h0);
  assign sa_clear = wr_fire && wr_off == OFF_STATUS && wdat[ST_SA_CHANGE];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sa_prev_q <= 5'h0;
      sa_prev_ok_q <= 1'b0;
      sa_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (rx_in.sa_valid) begin
        sa_prev_q <= rx_in.sa_bits;
        sa_prev_ok_q <= 1'b1;
      end
      if (sa_event) sa_flag_q <= 1'b1;
      else if (sa_clear) sa_flag_q <= 1'b0;
    end
  end

  // D4 remote alarm
  assign st_acc_now = alarm_acc_q || rx_in.ch_num == 5'h0;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      alarm_acc_q <= 1'b1;
      alarm_q <= 1'b0;
    end else if (clk_en && rx_in.t1_mode && rx_in.d4_mode) begin
      if (!sa_en_q[BIT_D4_ALARM_SEL] && rx_in.ch_valid) begin
        alarm_acc_q <= st_acc_now && !rx_in.ch_data[BIT_CH_BIT2];
        if (rx_in.ch_num == T1_LAST_CH) alarm_q <= st_acc_now && !rx_in.ch_data[BIT_CH_BIT2];
      end
      if (sa_en_q[BIT_D4_ALARM_SEL] && rx_in.sbit_valid && rx_in.frame_num == ALARM_FRAME) alarm_q <= rx_in.sbit;
    end
  end

  // Signaling capture
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < T1_CHANNELS; i++) sig_mem_q[i] <= 4'h0;
    end else if (clk_en && rx_in.sig_valid && !rx_in.sync_lost && rx_in.ch_num <= T1_LAST_CH) begin
      sig_mem_q[rx_in.ch_num] <= rx_in.d4_mode ? {rx_in.sig_abcd[3:2], rx_in.sig_abcd[3:2]} : rx_in.sig_abcd;
    end
  end

  // Serial data path
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_out <= '0;
      mw_phase_q <= 3'h0;
    end else if (clk_en) begin
      rx_out.out_valid <= rx_in.ch_valid;
      if (rx_in.sig_valid) rx_out.receive_signaling_out <= rx_in.sig_abcd;
      if (rx_in.ch_valid) begin
        rx_out.receive_serial_data_out <= rx_in.ch_data;
        if (rx_in.t1_mode && rx_in.ch_num <= T1_LAST_CH) begin
          if (mw_q[rx_in.ch_num]) rx_out.receive_serial_data_out <= MW_CODE[8 * (3'h7 - mw_phase_q) +: 8];
          else if (sig_ctrl_q[BIT_FORCE_ONES_EN] && force1_q[rx_in.ch_num] && rx_in.robbed_frame)
            rx_out.receive_serial_data_out <= rx_in.ch_data | 8'h01;
        end
        if ((rx_in.t1_mode && rx_in.ch_num <= T1_LAST_CH) || (!rx_in.t1_mode && rx_in.ch_num > T1_LAST_CH))
          rx_out.idle_code <= idle_mem_q[rx_in.ch_num];
        else rx_out.idle_code <= 8'h00;
        if (rx_in.ch_num == T1_LAST_CH) mw_phase_q <= mw_phase_q + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      remote_alarm <= 1'b0;
      bit_code_valid_status <= 1'b0;
      receive_latched_status_7 <= 1'b0;
    end else if (clk_en) begin
      remote_alarm <= alarm_q;
      bit_code_valid_status <= bc_valid_q;
      receive_latched_status_7 <= sa_flag_q;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_boc_self_clear;
    clk_en [*8] ##0 $rose(boc_ctrl_q[BIT_BOC_RESET]) |-> ##[1:12] !boc_ctrl_q[BIT_BOC_RESET];
  endproperty
  a_boc_self_clear: assert property (p_boc_self_clear) else $error("BOC reset bit did not self clear");
  property p_sa_set;
    clk_en && sa_event |=> sa_flag_q;
  endproperty
  a_sa_set: assert property (p_sa_set) else $error("Sa change not latched");
  property p_sa_masked;
    clk_en && !sa_flag_q && rx_in.sa_valid && ((rx_in.sa_bits ^ sa_prev_q) & sa_en_q[4:0]) == 5'h0 |=> !sa_flag_q;
  endproperty
  a_sa_masked: assert property (p_sa_masked) else $error("Masked Sa change latched");
  property p_sig_pass;
    clk_en && rx_in.sig_valid |=> rx_out.receive_signaling_out == $past(rx_in.sig_abcd);
  endproperty
  a_sig_pass: assert property (p_sig_pass) else $error("Signaling output altered");
  property p_force_ones;
    clk_en && rx_in.ch_valid && rx_in.t1_mode && rx_in.ch_num <= T1_LAST_CH && !mw_q[rx_in.ch_num]
      && sig_ctrl_q[BIT_FORCE_ONES_EN] && force1_q[rx_in.ch_num] && rx_in.robbed_frame
      |=> rx_out.receive_serial_data_out[BIT_ROBBED];
  endproperty
  a_force_ones: assert property (p_force_ones) else $error("Robbed bit not forced");
  property p_freeze;
    clk_en && rx_in.sync_lost && rx_in.ch_num <= T1_LAST_CH |=> sig_mem_q[$past(rx_in.ch_num)] == $past(sig_mem_q[rx_in.ch_num]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("Signaling updated during sync loss");
  property p_valid_cause;
    $rose(bc_valid_q) |-> $past(rx_in.boc_pattern_ok) && !$past(boc_ctrl_q[BIT_BOC_RESET]);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("BOC valid without pattern");
  property p_disint;
    $fell(bc_valid_q) && !$past(boc_ctrl_q[BIT_BOC_RESET]) |-> $past(disint_cnt_q) + 7'h1 == disint_count(disint_act_q);
  endproperty
  a_disint: assert property (p_disint) else $error("BOC cleared at wrong count");
  property p_alarm_sbit;
    clk_en && rx_in.t1_mode && rx_in.d4_mode && sa_en_q[BIT_D4_ALARM_SEL] && rx_in.sbit_valid
      && rx_in.frame_num == ALARM_FRAME |=> alarm_q == $past(rx_in.sbit);
  endproperty
  a_alarm_sbit: assert property (p_alarm_sbit) else $error("Frame 12 alarm not followed");
  property p_mw_replace;
    clk_en && rx_in.ch_valid && rx_in.t1_mode && rx_in.ch_num <= T1_LAST_CH && mw_q[rx_in.ch_num]
      |=> rx_out.receive_serial_data_out == MW_CODE[8 * (3'h7 - $past(mw_phase_q)) +: 8];
  endproperty
  a_mw_replace: assert property (p_mw_replace) else $error("Milliwatt code not inserted");
  property p_boc_restart;
    clk_en && boc_ctrl_q[BIT_BOC_RESET] |=> !bc_valid_q && integ_cnt_q == 3'h0 && disint_cnt_q == 7'h0;
  endproperty
  a_boc_restart: assert property (p_boc_restart) else $error("BOC counters not restarted");
  property p_idle_mode;
    clk_en && rx_in.ch_valid && rx_in.t1_mode && rx_in.ch_num > T1_LAST_CH |=> rx_out.idle_code == 8'h00;
  endproperty
  a_idle_mode: assert property (p_idle_mode) else $error("E1 idle code used in T1");

  c_boc_valid: cover property ($rose(bc_valid_q));
  c_sa_flag: cover property ($rose(sa_flag_q));
  c_alarm: cover property ($rose(alarm_q));
endmodule
`default_nettype wire

// *** hw/rx_framer_pkg.sv ***
`default_nettype none
package rx_framer_pkg;
  // Word index offsets within one port, byte address is four times the index
  localparam logic [8:0] OFF_SIG_CTRL = 9'h013;
  localparam logic [8:0] OFF_SA_IRQ_EN = 9'h014;
  localparam logic [8:0] OFF_BOC_CTRL = 9'h015;
  localparam logic [8:0] OFF_IDLE_FIRST = 9'h020;
  localparam logic [8:0] OFF_IDLE_LAST = 9'h03F;
  localparam logic [8:0] OFF_RECEIVE_SIGNALING_OUT_FIRST = 9'h040;
  localparam logic [8:0] OFF_RECEIVE_SIGNALING_OUT_LAST = 9'h04F;
  localparam logic [8:0] OFF_FORCE1_FIRST = 9'h0A0;
  localparam logic [8:0] OFF_MW_FIRST = 9'h0A3;
  localparam logic [8:0] OFF_STATUS = 9'h0A6;
  localparam logic [10:0] PORT_STRIDE = 11'h200;
  localparam int PORT_IDX_LSB = 9;
  localparam int NUM_PORTS = 4;
  localparam int T1_CHANNELS = 24;
  localparam int ALL_CHANNELS = 32;
  localparam int RECEIVE_SIGNALING_OUT_T1_BYTES = 12;
  localparam logic [4:0] T1_LAST_CH = 5'h17;
  localparam logic [3:0] ALARM_FRAME = 4'hC;
  // Field positions
  localparam int BIT_FORCE_ONES_EN = 4;
  localparam int BIT_D4_ALARM_SEL = 0;
  localparam int BIT_BOC_RESET = 7;
  localparam int BIT_CH_BIT2 = 6;
  localparam int BIT_ROBBED = 0;
  localparam int ST_SA_CHANGE = 0;
  localparam int ST_BOC_VALID = 1;
  localparam int ST_REMOTE_ALARM = 2;
  localparam logic [7:0] SA_IRQ_MASK = 8'h1F;
  localparam logic [7:0] BOC_CTRL_MASK = 8'h36;
  localparam logic [7:0] SIG_CTRL_MASK = 8'h17;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // BOC reset completion, must stay below the documented ceiling
  localparam int CLK_PERIOD_NS = 40;
  localparam int BOC_RST_MAX_NS = 250000;
  localparam int BOC_RST_MAX_CYC = BOC_RST_MAX_NS / CLK_PERIOD_NS;
  localparam logic [3:0] BOC_RST_LEN = 4'h8;
  localparam logic [6:0] DISINT_UNIT = 7'h10;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic t1_mode;
    logic d4_mode;
    logic sync_lost;
    logic ch_valid;
    logic [4:0] ch_num;
    logic [7:0] ch_data;
    logic robbed_frame;
    logic sig_valid;
    logic [3:0] sig_abcd;
    logic sbit_valid;
    logic sbit;
    logic [3:0] frame_num;
    logic sa_valid;
    logic [4:0] sa_bits;
    logic boc_bit;
    logic boc_pattern_ok;
    logic boc_pattern_err;
  } rx_stream_s;

  typedef struct packed {
    logic out_valid;
    logic [7:0] receive_serial_data_out;
    logic [3:0] receive_signaling_out;
    logic [7:0] idle_code;
  } rx_out_s;
endpackage
`default_nettype wire

// *** tb/rx_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_line_model (
  input wire logic ref_clk,
  output var rx_framer_pkg::rx_stream_s rx_in
);
  import rx_framer_pkg::*;

  initial rx_in = '0;

  // One strobe for one cycle; levels persist, data fields stop showing old values
  task automatic strobe(input rx_stream_s s);
    rx_in <= s;
    @(posedge ref_clk);
    rx_in.ch_valid <= 1'h0;
    rx_in.sig_valid <= 1'h0;
    rx_in.sbit_valid <= 1'h0;
    rx_in.sa_valid <= 1'h0;
    rx_in.boc_bit <= 1'h0;
    rx_in.boc_pattern_ok <= 1'h0;
    rx_in.boc_pattern_err <= 1'h0;
    rx_in.ch_data <= ~s.ch_data;
    rx_in.sig_abcd <= ~s.sig_abcd;
    rx_in.sa_bits <= ~s.sa_bits;
    rx_in.sbit <= ~s.sbit;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_rx_framer_boc_sig_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_rx_framer_boc_sig_ctrl;
  import rx_framer_pkg::*;
  localparam logic [63:0] MW = 64'h1E0B0B1E9E8B8B9E;
  localparam logic [10:0] BASE = 11'h200;
  localparam int CH = 0, SIG = 1, SA = 2, SBIT = 3, BOK = 4, BBIT = 5;
  typedef struct packed {
    logic [10:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_s;
  row_s rows [9] = '{
    '{11'h014, 8'hFF, 8'h00},
    '{11'h614, 8'hFF, 8'h00},
    '{11'h214, 8'hFF, 8'h1F},
    '{11'h213, 8'hFF, 8'h17},
    '{11'h220, 8'hA5, 8'hA5},
    '{11'h23F, 8'h3C, 8'h3C},
    '{11'h240, 8'hFF, 8'h00},
    '{11'h2A0, 8'h80, 8'h80},
    '{11'h2A3, 8'h80, 8'h80}
  };
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  rx_stream_s rx_in;
  rx_stream_s st = '0;
  rx_out_s rx_out;
  logic remote_alarm;
  logic bit_code_valid_status;
  logic receive_latched_status_7;
  logic [31:0] x;
  int fail_count = 0;
  int samples_checked = 0;

  always #20 ref_clk = ~ref_clk;

  rx_framer_boc_sig_ctrl #(.PORT_INDEX(2'h1), .MW_CODE(MW)) DUT (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(1'h1),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rx_in(rx_in),
    .rx_out(rx_out),
    .remote_alarm(remote_alarm),
    .bit_code_valid_status(bit_code_valid_status),
    .receive_latched_status_7(receive_latched_status_7)
  );

  rx_line_model line_src (
    .ref_clk(ref_clk),
    .rx_in(rx_in)
  );

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
    samples_checked++;
    if (got !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic bus_xfer(input logic wr_en, input logic [10:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr_en;
    haddr <= {19'h0, idx, 2'h0};
    do @(posedge ref_clk); while (hreadyout !== 1'h1 && ++n < 50);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge ref_clk); while (hreadyout !== 1'h1 && ++n < 50);
    if (n >= 50) fail_count++;
    x = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    bus_xfer(1'h1, BASE + 11'(idx), d);
  endtask

  task automatic rd_chk(input string what, input logic [8:0] idx, input logic [7:0] e);
    bus_xfer(1'h0, BASE + 11'(idx), 8'h00);
    check(what, {24'h0, e}, x);
  endtask

  task automatic pulse(input int kind, input logic [4:0] ch, input logic [7:0] d);
    rx_stream_s s;
    s = st;
    s.ch_num = ch;
    s.ch_data = d;
    s.sig_abcd = d[3:0];
    s.sa_bits = d[4:0];
    s.sbit = d[0];
    s.frame_num = ch[3:0];
    case (kind)
      CH: s.ch_valid = 1'h1;
      SIG: s.sig_valid = 1'h1;
      SA: s.sa_valid = 1'h1;
      SBIT: s.sbit_valid = 1'h1;
      BOK: s.boc_pattern_ok = 1'h1;
      default: s.boc_bit = 1'h1;
    endcase
    line_src.strobe(s);
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic bit_chk(input string what, input logic e, ref logic got);
    settle();
    check(what, {31'h0, e}, {31'h0, got});
  endtask

  task automatic boc_reset(input logic [7:0] v);
    int n;
    n = 0;
    wr(OFF_BOC_CTRL, v | 8'h80);
    do begin
      bus_xfer(1'h0, BASE + 11'(OFF_BOC_CTRL), 8'h00);
      n++;
    end while (x[7] !== 1'h0 && n < 100);
    check("boc control after reset", {24'h0, v & BOC_CTRL_MASK}, x);
  endtask

  task automatic boc_cycle(input int nf, input int nd);
    repeat (nf - 1) pulse(BOK, 5'h0, 8'h00);
    bit_chk("boc valid early", 1'h0, bit_code_valid_status);
    pulse(BOK, 5'h0, 8'h00);
    bit_chk("boc valid", 1'h1, bit_code_valid_status);
    repeat (nd - 1) pulse(BBIT, 5'h0, 8'h00);
    bit_chk("boc hold", 1'h1, bit_code_valid_status);
    pulse(BBIT, 5'h0, 8'h00);
    bit_chk("boc clear", 1'h0, bit_code_valid_status);
  endtask

  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge ref_clk);
    foreach (rows[i]) begin
      bus_xfer(1'h0, rows[i].idx, 8'h00);
      check("reset value", 32'h0, x);
      bus_xfer(1'h1, rows[i].idx, rows[i].wd);
      bus_xfer(1'h0, rows[i].idx, 8'h00);
      check("readback", {24'h0, rows[i].exp}, x);
    end
    st.t1_mode = 1'h1;
    for (int f = 0; f < 4; f++) begin
      boc_reset(8'((f << 4) | (f << 1)));
      boc_cycle(2 * f + 1, 16 * f + 16);
    end
    // New filter without a reset must not take effect yet
    wr(OFF_BOC_CTRL, 8'h02);
    boc_cycle(7, 64);
    st.t1_mode = 1'h0;
    pulse(CH, 5'h1F, 8'h54);
    check("e1 idle", 32'h3C, {24'h0, rx_out.idle_code});
    wr(OFF_SA_IRQ_EN, 8'h10);
    pulse(SA, 5'h0, 8'h00);
    pulse(SA, 5'h0, 8'h01);
    bit_chk("sa masked", 1'h0, receive_latched_status_7);
    pulse(SA, 5'h0, 8'h11);
    bit_chk("sa change", 1'h1, receive_latched_status_7);
    rd_chk("status", OFF_STATUS, 8'h01);
    wr(OFF_STATUS, 8'h01);
    pulse(SA, 5'h0, 8'h11);
    bit_chk("sa unchanged", 1'h0, receive_latched_status_7);
    st.t1_mode = 1'h1;
    st.robbed_frame = 1'h1;
    wr(OFF_SIG_CTRL, 8'h10);
    wr(OFF_FORCE1_FIRST, 8'h01);
    wr(OFF_MW_FIRST, 8'h02);
    pulse(CH, 5'h0, 8'h54);
    check("forced data", 32'h55, {24'h0, rx_out.receive_serial_data_out});
    check("out valid", 32'h1, {31'h0, rx_out.out_valid});
    check("idle code", 32'hA5, {24'h0, rx_out.idle_code});
    pulse(CH, 5'h1, 8'h54);
    check("milliwatt", {24'h0, MW[63:56]}, {24'h0, rx_out.receive_serial_data_out});
    pulse(CH, 5'h1F, 8'h54);
    check("plain data", 32'h54, {24'h0, rx_out.receive_serial_data_out});
    check("e1 idle in t1", 32'h0, {24'h0, rx_out.idle_code});
    pulse(SIG, 5'h0, 8'h05);
    check("signaling out", 32'h5, {28'h0, rx_out.receive_signaling_out});
    wr(OFF_SIG_CTRL, 8'h00);
    pulse(CH, 5'h0, 8'h54);
    check("force off", 32'h54, {24'h0, rx_out.receive_serial_data_out});
    pulse(SIG, 5'h0, 8'h0A);
    pulse(SIG, 5'hC, 8'h03);
    rd_chk("sig byte 0", OFF_RECEIVE_SIGNALING_OUT_FIRST, 8'hA3);
    st.sync_lost = 1'h1;
    pulse(SIG, 5'h0, 8'h05);
    rd_chk("sig frozen", OFF_RECEIVE_SIGNALING_OUT_FIRST, 8'hA3);
    st.sync_lost = 1'h0;
    st.d4_mode = 1'h1;
    pulse(SIG, 5'h1, 8'h08);
    rd_chk("sig d4 repeat", OFF_RECEIVE_SIGNALING_OUT_FIRST + 9'h1, 8'hA0);
    wr(OFF_SA_IRQ_EN, 8'h00);
    for (int c = 0; c < 24; c++) pulse(CH, 5'(c), 8'h80);
    bit_chk("alarm bit2", 1'h1, remote_alarm);
    for (int c = 0; c < 24; c++) pulse(CH, 5'(c), (c == 5) ? 8'h40 : 8'h00);
    bit_chk("alarm one ch", 1'h0, remote_alarm);
    wr(OFF_SA_IRQ_EN, 8'h01);
    pulse(SBIT, 5'hC, 8'h01);
    bit_chk("alarm frame 12", 1'h1, remote_alarm);
    pulse(SBIT, 5'hC, 8'h00);
    pulse(SBIT, 5'hB, 8'h01);
    bit_chk("alarm frame 11", 1'h0, remote_alarm);
    sys_rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rd_chk("sa enables reset", OFF_SA_IRQ_EN, 8'h00);
    rd_chk("idle reset", OFF_IDLE_FIRST, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
